// ---- logic/rcp_core.v ----
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "rcp_defs.vh"
module rcp_core (
    input  wire        clk,
    input  wire        srst,
    output wire [11:0] progAddr,
    input  wire [11:0] progData,
    input  wire [3:0]  regAddr,
    input  wire [7:0]  regWrData,
    input  wire        regWr,
    input  wire        regRd,
    output wire [7:0]  regRdData,
    output wire        retire,
    output wire        halted
);

// ********************************************************
// state
// ********************************************************
reg  [11:0] progAddr_q;
reg         fetchVld_q;
reg         wordPend_q;
reg  [11:0] resume_q;
reg  [11:0] decIr_q;
reg  [11:0] decLoc_q;
reg         decVld_q;
reg  [11:0] exIr_q;
reg  [11:0] exLoc_q;
reg         exVld_q;
reg         retire_q;
reg         halted_q;
reg  [7:0]  wreg_q;
reg  [7:0]  status_q;
reg  [7:0]  status_d;
reg  [7:0]  ptr_q;
reg  [7:0]  mode_q;
reg  [7:0]  option_q;
reg  [7:0]  mem_q [0:255];
reg  [11:0] stack_q [0:`RCP_STK_DEPTH-1];
reg         run_q;
reg  [3:0]  cfgHi_q;
reg  [1:0]  div_q;
reg  [7:0]  rdData_q;
reg  [7:0]  rdVal;
integer     i;

// ********************************************************
// stepping and soft reset events
// ********************************************************
wire wdogEv = regWr && (regAddr == `RCP_R_CTRL) && regWrData[`RCP_C_WDOG];
wire extEv  = regWr && (regAddr == `RCP_R_CTRL) && regWrData[`RCP_C_EXT];
// divide by one unless config word bit 11 is set, then every 4th clock
wire step   = run_q && (!cfgHi_q[`RCP_CFG_DIV] ||
                        (div_q == `RCP_DIV_LAST));
wire exOn   = exVld_q && step;

// ********************************************************
// execute stage: operand fetch and alu
// ********************************************************
wire [4:0]  fld     = exIr_q[`RCP_F_REG];
wire [7:0]  lit     = exIr_q[`RCP_F_LIT];
wire [11:0] locNext = exLoc_q + 12'h001;
reg  [7:0]  opAddr;
reg  [7:0]  opVal;
// alias with zero field uses the pointer; banked field is semidirect
always @* begin
    if (fld == 5'h00)
        opAddr = ptr_q;
    else if (fld[`RCP_F_BANKED])
        opAddr = {ptr_q[`RCP_P_HI], fld[`RCP_F_LOW]};
    else
        opAddr = {4'h0, fld[`RCP_F_LOW]};
end

// mapped specials sit in front of the flop array
always @* begin
    case (opAddr)
        `RCP_A_ALIAS:  opVal = 8'h00;  // alias pointing at itself
        `RCP_A_LOC:    opVal = locNext[`RCP_W_LO];
        `RCP_A_STATUS: opVal = status_q;
        `RCP_A_PTR:    opVal = ptr_q;
        default:       opVal = mem_q[opAddr];
    endcase
end

wire [8:0] addSum  = {1'b0, opVal} + {1'b0, wreg_q};
wire [8:0] subDif  = {1'b0, opVal} - {1'b0, wreg_q};
wire [4:0] addLo   = {1'b0, opVal[3:0]} + {1'b0, wreg_q[3:0]};
wire [7:0] bitMask = 8'h01 << exIr_q[`RCP_F_BIT];
wire [7:0] incVal  = opVal + 8'h01;
wire [7:0] decVal  = opVal - 8'h01;

reg [7:0] res;
reg       dst, wrF, wrW, updZ, updC, updDc, newC, newDc, skip;
reg       wordRd, sleep, clrWd, pageWr, bankWr, modeWr, modeLit, optWr;
// one decoder for all three instruction groups
always @* begin
    res = opVal; dst = 1'b0; wrF = 1'b0; wrW = 1'b0;
    updZ = 1'b0; updC = 1'b0; updDc = 1'b0;
    newC = status_q[`RCP_ST_C]; newDc = status_q[`RCP_ST_DC];
    skip = 1'b0; wordRd = 1'b0; sleep = 1'b0; clrWd = 1'b0;
    pageWr = 1'b0; bankWr = 1'b0; modeWr = 1'b0; modeLit = 1'b0;
    optWr = 1'b0;
    casez (exIr_q)
        12'b0000_0000_0010: optWr = 1'b1;
        12'b0000_0000_0011: sleep = 1'b1;
        12'b0000_0000_0100: clrWd = 1'b1;
        12'b0000_0001_0???: pageWr = 1'b1;
        12'b0000_0001_1???: bankWr = 1'b1;
        12'b0000_0100_0000: begin
            res = 8'h00; wrW = 1'b1; updZ = 1'b1;
        end
        12'b0000_0100_0001: wordRd = 1'b1;
        12'b0000_0100_0010: begin res = mode_q; wrW = 1'b1; end
        12'b0000_0100_0011: modeWr = 1'b1;
        12'b0000_0101_????: modeLit = 1'b1;
        12'b0000_001?_????: begin res = wreg_q; wrF = 1'b1; end
        12'b0000_011?_????: begin res = 8'h00; wrF = 1'b1; updZ = 1'b1; end
        12'b0000_10??_????: begin
            res = subDif[7:0]; dst = 1'b1; updZ = 1'b1;
            updC = 1'b1; newC = ~subDif[8];
            updDc = 1'b1; newDc = (opVal[3:0] >= wreg_q[3:0]);
        end
        12'b0000_11??_????: begin res = decVal; dst = 1'b1; updZ = 1'b1; end
        12'b0001_00??_????: begin
            res = opVal | wreg_q; dst = 1'b1; updZ = 1'b1;
        end
        12'b0001_01??_????: begin
            res = opVal & wreg_q; dst = 1'b1; updZ = 1'b1;
        end
        12'b0001_10??_????: begin
            res = opVal ^ wreg_q; dst = 1'b1; updZ = 1'b1;
        end
        12'b0001_11??_????: begin
            res = addSum[7:0]; dst = 1'b1; updZ = 1'b1;
            updC = 1'b1; newC = addSum[8];
            updDc = 1'b1; newDc = addLo[4];
        end
        12'b0010_00??_????: begin dst = 1'b1; updZ = 1'b1; end
        12'b0010_01??_????: begin res = ~opVal; dst = 1'b1; updZ = 1'b1; end
        12'b0010_10??_????: begin res = incVal; dst = 1'b1; updZ = 1'b1; end
        12'b0010_11??_????: begin
            res = decVal; dst = 1'b1; skip = (decVal == 8'h00);
        end
        12'b0011_00??_????: begin
            res = {status_q[`RCP_ST_C], opVal[7:1]}; dst = 1'b1;
            updC = 1'b1; newC = opVal[0];
        end
        12'b0011_01??_????: begin
            res = {opVal[6:0], status_q[`RCP_ST_C]}; dst = 1'b1;
            updC = 1'b1; newC = opVal[7];
        end
        12'b0011_10??_????: begin
            res = {opVal[3:0], opVal[7:4]}; dst = 1'b1;
        end
        12'b0011_11??_????: begin
            res = incVal; dst = 1'b1; skip = (incVal == 8'h00);
        end
        12'b0100_????_????: begin res = opVal & ~bitMask; wrF = 1'b1; end
        12'b0101_????_????: begin res = opVal | bitMask; wrF = 1'b1; end
        12'b0110_????_????: skip = ((opVal & bitMask) == 8'h00);
        12'b0111_????_????: skip = ((opVal & bitMask) != 8'h00);
        12'b1000_????_????: begin res = lit; wrW = 1'b1; end
        12'b1100_????_????: begin res = lit; wrW = 1'b1; end
        12'b1101_????_????: begin
            res = lit | wreg_q; wrW = 1'b1; updZ = 1'b1;
        end
        12'b1110_????_????: begin
            res = lit & wreg_q; wrW = 1'b1; updZ = 1'b1;
        end
        12'b1111_????_????: begin
            res = lit ^ wreg_q; wrW = 1'b1; updZ = 1'b1;
        end
        default: ;  // jumps, calls and returns act in decode
    endcase
    if (dst) begin
        wrF = exIr_q[`RCP_F_DST];
        wrW = ~exIr_q[`RCP_F_DST];
    end
end

wire locWr  = wrF && (opAddr == `RCP_A_LOC);
wire memWr  = wrF && (opAddr != `RCP_A_ALIAS) && (opAddr != `RCP_A_LOC) &&
              (opAddr != `RCP_A_STATUS) && (opAddr != `RCP_A_PTR);
// writing the low byte clears bit 8 and pulls in the page bits
wire [11:0] newLoc = {status_q[`RCP_ST_PAGE], 1'b0, res};
wire skipDec = exOn && skip;
wire exFlush = exOn && (locWr || wordRd || sleep);

// ********************************************************
// decode stage: jumps, calls and returns
// ********************************************************
wire decOn  = decVld_q && step && !skipDec && !exFlush;
wire isGoto = (decIr_q[11:9] == 3'b101);
wire isCall = (decIr_q[11:8] == 4'b1001);
wire isRetw = (decIr_q[11:8] == 4'b1000);
wire isRet  = (decIr_q[11:2] == 10'b0000_0000_11);
wire isRetp = (decIr_q == 12'h00D);
wire isPop  = isRet || isRetw;
wire redirect = decOn && (isGoto || isCall || isPop);
reg  [11:0] target;
// page bits come from the forwarded status so a page set just ahead counts
always @* begin
    if (isGoto)
        target = {status_d[`RCP_ST_PAGE], decIr_q[`RCP_F_GOTO]};
    else if (isCall)
        target = {status_d[`RCP_ST_PAGE], 1'b0, decIr_q[`RCP_F_LIT]};
    else
        target = stack_q[0];
end

// ********************************************************
// status next value
// ********************************************************
always @* begin
    status_d = status_q;
    if (exOn) begin
        if (wrF && (opAddr == `RCP_A_STATUS))
            status_d = {res[`RCP_ST_PAGE], status_q[`RCP_ST_TP],
                        res[`RCP_ST_LOW]};
        if (updZ)
            status_d[`RCP_ST_Z] = (res == 8'h00);
        if (updC)
            status_d[`RCP_ST_C] = newC;
        if (updDc)
            status_d[`RCP_ST_DC] = newDc;
        if (pageWr)
            status_d[`RCP_ST_PAGE] = exIr_q[`RCP_F_SEL];
        if (sleep)
            status_d[`RCP_ST_TP] = 2'b10;
        if (clrWd)
            status_d[`RCP_ST_TP] = 2'b11;
    end
    if (decOn && isRetp)
        status_d[`RCP_ST_PAGE] = stack_q[0][`RCP_L_PAGE];
end

// ********************************************************
// pipeline sequencing
// ********************************************************
// fetch presents progAddr; memory answers in the same cycle
always @(posedge clk) begin
    if (srst || wdogEv || extEv) begin
        progAddr_q <= `RCP_LOC_RST;
        fetchVld_q <= 1'b1;
        decVld_q   <= 1'b0;
        exVld_q    <= 1'b0;
        wordPend_q <= 1'b0;
        halted_q   <= 1'b0;
        retire_q   <= 1'b0;
    end else begin
        retire_q <= exOn;
        if (step) begin
            decIr_q  <= progData;
            decLoc_q <= progAddr_q;
            exIr_q   <= decIr_q;
            exLoc_q  <= decLoc_q;
            exVld_q  <= decVld_q && !skipDec && !exFlush;
            if (exOn && sleep) begin
                halted_q   <= 1'b1;
                fetchVld_q <= 1'b0;
                decVld_q   <= 1'b0;
            end else if (exOn && wordRd) begin
                // borrow the fetch port for one cycle, then resume
                progAddr_q <= {mode_q[`RCP_F_LOW], wreg_q};
                fetchVld_q <= 1'b0;
                decVld_q   <= 1'b0;
                wordPend_q <= 1'b1;
                resume_q   <= locNext;
            end else if (exOn && locWr) begin
                progAddr_q <= newLoc;
                fetchVld_q <= 1'b1;
                decVld_q   <= 1'b0;
            end else if (wordPend_q) begin
                progAddr_q <= resume_q;
                fetchVld_q <= 1'b1;
                decVld_q   <= 1'b0;
                wordPend_q <= 1'b0;
            end else if (redirect) begin
                progAddr_q <= target;
                fetchVld_q <= 1'b1;
                decVld_q   <= 1'b0;
            end else if (!halted_q) begin
                progAddr_q <= progAddr_q + 12'h001;
                decVld_q   <= fetchVld_q;
                fetchVld_q <= 1'b1;
            end else begin
                decVld_q <= 1'b0;
            end
        end
    end
end

// ********************************************************
// accumulator, pointer, status and mode registers
// ********************************************************
// a watchdog event beats an external one written in the same cycle
wire [1:0] tpSoft = wdogEv ? (halted_q ? 2'b00 : 2'b01) :
                    (halted_q ? 2'b10 : status_q[`RCP_ST_TP]);
always @(posedge clk) begin
    if (srst) begin
        status_q <= `RCP_STATUS_POR;
        ptr_q    <= `RCP_PTR_POR;
        mode_q   <= `RCP_MODE_RST;
        option_q <= `RCP_OPT_RST;
        wreg_q   <= 8'h00;
    end else if (wdogEv || extEv) begin
        status_q <= {3'b000, tpSoft, status_q[`RCP_ST_LOW]};
        ptr_q[`RCP_P_TOP] <= 1'b1;
        mode_q   <= `RCP_MODE_RST;
        option_q <= `RCP_OPT_RST;
    end else begin
        status_q <= status_d;
        if (wordPend_q && step) begin
            wreg_q <= progData[`RCP_W_LO];
            mode_q <= {4'h0, progData[`RCP_W_HI]};
        end
        if (exOn) begin
            if (wrW)
                wreg_q <= res;
            if (wrF && (opAddr == `RCP_A_PTR))
                ptr_q <= res;
            if (bankWr)
                ptr_q[`RCP_P_BANK] <= exIr_q[`RCP_F_SEL];
            if (modeWr)
                mode_q <= wreg_q;
            if (modeLit)
                mode_q <= {4'h0, exIr_q[`RCP_F_LOW]};
            if (optWr)
                option_q <= wreg_q;
        end
    end
end

// file array holds data across soft resets, so it has no reset
always @(posedge clk) begin
    if (exOn && memWr)
        mem_q[opAddr] <= res;
end

// ********************************************************
// return stack
// ********************************************************
always @(posedge clk) begin
    if (decOn && isCall) begin
        for (i = `RCP_STK_DEPTH - 1; i > 0; i = i - 1)
            stack_q[i] <= stack_q[i-1];
        stack_q[0] <= decLoc_q + 12'h001;
    end else if (decOn && isPop) begin
        for (i = 0; i < `RCP_STK_DEPTH - 1; i = i + 1)
            stack_q[i] <= stack_q[i+1];
    end
end

// ********************************************************
// register port
// ********************************************************
always @* begin
    rdVal = 8'h00;
    case (regAddr)
        `RCP_R_CTRL: begin
            rdVal[`RCP_C_RUN]  = run_q;
            rdVal[`RCP_C_HALT] = halted_q;
        end
        `RCP_R_CFG:  rdVal = {4'h0, cfgHi_q};
        `RCP_R_LOCL: rdVal = progAddr_q[`RCP_W_LO];
        `RCP_R_LOCH: rdVal = {4'h0, progAddr_q[`RCP_L_HI]};
        `RCP_R_WREG: rdVal = wreg_q;
        `RCP_R_STAT: rdVal = status_q;
        `RCP_R_PTR:  rdVal = ptr_q;
        `RCP_R_OPT:  rdVal = option_q;
        default:     rdVal = 8'h00;
    endcase
end

// read data stands only in the cycle after the strobe
always @(posedge clk) begin
    if (srst) begin
        run_q    <= 1'b1;
        cfgHi_q  <= 4'h0;
        div_q    <= 2'h0;
        rdData_q <= 8'h00;
    end else begin
        div_q    <= div_q + 2'h1;
        rdData_q <= regRd ? rdVal : 8'h00;
        if (regWr && (regAddr == `RCP_R_CTRL))
            run_q <= regWrData[`RCP_C_RUN];
        if (regWr && (regAddr == `RCP_R_CFG))
            cfgHi_q <= regWrData[`RCP_CFG_BITS];
    end
end

assign progAddr  = progAddr_q;
assign regRdData = rdData_q;
assign retire    = retire_q;
assign halted    = halted_q;

endmodule // rcp_core
`default_nettype wire

// ---- logic/rcp_defs.vh ----
// Summary of operation
// - every instruction is one 12-bit word
// - one cycle; jumps, calls, returns, taken skips two; counter writes three, word reads four
// - three overlapped stages: fetch, decode, execute
// - full pipeline retires one instruction per clock
// - counter changes flush and refill the pipeline
// - config word bit 11 low: divide by one
// - accumulator: second operand, literals, destination
// - selected bank file registers: first operand, destination
// - status register mapped with testable flags
// - mapped counter low byte gives computed branches
// - indirect alias operates on pointed register
// - program word read from mode and accumulator
// - eight-level 12-bit return stack
// - bank instruction loads pointer bits 4 to 6
// - pointer bit 7 selects bank group
// - bit set, clear and skip on either
// - watchdog reset: flags 00 halted, 01 active
// - external reset: flags 10 halted, else kept
// - decoder holds byte, bit, literal/control groups
// - direct, indirect, semidirect, immediate, program modes
// - jump: nine target bits plus page bits
// - call: push, eight bits, bit eight clear
// - push shifts down, deepest entry lost
// - return pops, deepest entry duplicated
`ifndef RCP_DEFS_VH
`define RCP_DEFS_VH
// ********************************************************
// reset values
// ********************************************************
`define RCP_LOC_RST    12'hFFF
`define RCP_STATUS_POR 8'h18
`define RCP_PTR_POR    8'h80
`define RCP_MODE_RST   8'h1F
`define RCP_OPT_RST    8'hFF
// ********************************************************
// status bits and data space addresses
// ********************************************************
`define RCP_ST_C       0
`define RCP_ST_DC      1
`define RCP_ST_Z       2
`define RCP_ST_TP      4:3
`define RCP_ST_LOW     2:0
`define RCP_ST_PAGE    7:5
`define RCP_A_ALIAS    8'h00
`define RCP_A_LOC      8'h02
`define RCP_A_STATUS   8'h03
`define RCP_A_PTR      8'h04
// ********************************************************
// instruction and pointer fields
// ********************************************************
`define RCP_F_REG      4:0
`define RCP_F_BANKED   4
`define RCP_F_LOW      3:0
`define RCP_F_DST      5
`define RCP_F_BIT      7:5
`define RCP_F_LIT      7:0
`define RCP_F_GOTO     8:0
`define RCP_F_SEL      2:0
`define RCP_P_HI       7:4
`define RCP_P_BANK     6:4
`define RCP_P_TOP      7
`define RCP_W_LO       7:0
`define RCP_W_HI       11:8
`define RCP_L_HI       11:8
`define RCP_L_PAGE     11:9
`define RCP_STK_DEPTH  8
// ********************************************************
// register port map
// ********************************************************
`define RCP_R_CTRL     4'h0
`define RCP_R_CFG      4'h1
`define RCP_R_LOCL     4'h2
`define RCP_R_LOCH     4'h3
`define RCP_R_WREG     4'h4
`define RCP_R_STAT     4'h5
`define RCP_R_PTR      4'h6
`define RCP_R_OPT      4'h7
`define RCP_C_RUN      0
`define RCP_C_WDOG     1
`define RCP_C_EXT      2
`define RCP_C_HALT     3
`define RCP_CFG_BITS   3:0
`define RCP_CFG_DIV    3
`define RCP_DIV_LAST   2'h3
`endif

// ---- verif/rcp_core_sva.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "rcp_defs.vh"
// ****************************************************
// port level checks of the core
// ****************************************************
// boot checks lean on the bench keeping a jump to 000 at FFF
module rcp_core_chk (
    input wire logic        clk,
    input wire logic        srst,
    input wire logic [11:0] progAddr,
    input wire logic [11:0] progData,
    input wire logic [3:0]  regAddr,
    input wire logic [7:0]  regWrData,
    input wire logic        regWr,
    input wire logic        regRd,
    input wire logic [7:0]  regRdData,
    input wire logic        retire,
    input wire logic        halted
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // jump at the vector flushes J+1 and refills from the target
    a_boot_fetch: assert property (
        $fell(srst) |-> progAddr == 12'hFFF && !halted
            ##1 progAddr == 12'h000 ##1 progAddr == 12'h000
            ##1 progAddr == 12'h001)
        else $error("fetch order after reset is off");
    // jump retires after three stages, costs two, then one per clock
    a_boot_retire: assert property (
        $fell(srst) |-> !retire [*3] ##1 retire ##1 !retire
            ##1 retire [*2])
        else $error("retire timing after reset is off");
    // soft reset behaves like the pin reset for the pipeline
    a_soft_restart: assert property (
        regWr && regAddr == `RCP_R_CTRL && (regWrData[2] || regWrData[1])
            |=> progAddr == 12'hFFF ##1 progAddr == 12'h000
            ##1 progAddr == 12'h000)
        else $error("soft reset did not restart the fetch");
    a_halt_wake: assert property (
        halted && regWr && regAddr == `RCP_R_CTRL && regWrData[2:1] != 2'h0
            |=> !halted)
        else $error("soft reset left the core halted");
    // a halted core must neither fetch nor retire
    a_halt_freeze: assert property (
        halted && $past(halted) |-> !retire && $stable(progAddr))
        else $error("halted core still moves");
    a_read_window: assert property (
        !$past(regRd) |-> regRdData == 8'h00)
        else $error("read data outside its cycle");
    a_unmapped_read: assert property (
        regRd && regAddr[3] |=> regRdData == 8'h00)
        else $error("unmapped read returned data");
    a_ctrl_state: assert property (
        regRd && regAddr == `RCP_R_CTRL
            |=> regRdData[3] == $past(halted) && regRdData[2:1] == 2'h0)
        else $error("control read does not show the halt state");
endmodule // rcp_core_chk
bind rcp_core rcp_core_chk u_chk (
    .clk(clk), .srst(srst), .progAddr(progAddr), .progData(progData),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData), .retire(retire),
    .halted(halted)
);
`default_nettype wire

// ---- verif/rcp_pmem.sv ----
`timescale 1ns/10ps
`default_nettype none
// ****************************************************
// program memory model
// ****************************************************
// asynchronous read: the word must match the address in the same cycle
module rcp_pmem (
    input  wire logic [11:0] progAddr,
    output logic      [11:0] progData
);
    logic [11:0] mem [0:4095];
    // combinational read, the bench loads the array directly
    assign progData = mem[progAddr];
endmodule // rcp_pmem
`default_nettype wire

// ---- verif/test_risc_core_pipeline_and_addressing.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "rcp_defs.vh"
// ****************************************************
// core bench
// ****************************************************
module test_risc_core_pipeline_and_addressing;
    logic        clk;
    logic        srst;
    logic        regWr;
    logic        regRd;
    logic [3:0]  regAddr;
    logic [7:0]  regWrData;
    wire  [11:0] progAddr;
    wire  [11:0] progData;
    wire  [7:0]  regRdData;
    wire         retire;
    wire         halted;
    logic [15:0] expQ [$];
    logic [15:0] note;
    logic        rdLate;
    logic [31:0] rnd;
    logic [7:0]  rndB;
    logic [7:0]  expW;
    logic [2:0]  rndK;
    logic [2:0]  rndL;
    int          err_count;
    int          n_tests;
    int          seed;
    int          i;

    rcp_core dut (.clk(clk), .srst(srst), .progAddr(progAddr),
        .progData(progData), .regAddr(regAddr), .regWrData(regWrData),
        .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
        .retire(retire), .halted(halted));
    rcp_pmem pm (.progAddr(progAddr), .progData(progData));

    // free running 40 MHz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h, expected %h",
                $time, seen, exp);
        end
    endtask

    task give_verdict;
        $display("comparisons %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // strobes stay up past the edge so back to back calls never drop
    // and raise one strobe in a single step; rel takes them down
    task wr(input logic [3:0] a, input logic [7:0] d);
        regRd <= 1'b0;
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge clk);
    endtask

    // the note carries a mask so only defined bits are compared
    task rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
        expQ.push_back({m, e});
        regWr <= 1'b0;
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
    endtask

    task rel;
        regWr <= 1'b0;
        regRd <= 1'b0;
    endtask

    // bounded waits, sampled mid-cycle where outputs have settled
    task wait_halt;
        rel();
        for (i = 0; i < 300; i++) begin
            @(negedge clk);
            if (halted === 1'b1) break;
        end
        check({7'h00, halted}, 8'h01);
        @(posedge clk);
    endtask

    task wait_pc(input logic [11:0] a);
        rel();
        for (i = 0; i < 300; i++) begin
            @(negedge clk);
            if (progAddr === a) break;
        end
        check(progAddr[7:0], a[7:0]);
        @(posedge clk);
    endtask

    // read data stands only in the cycle after the strobe edge
    always @(posedge clk) begin
        if (rdLate) begin
            note = expQ.pop_front();
            check(regRdData & note[15:8], note[7:0]);
        end
        rdLate <= regRd;
    end

    // hang guard, the run needs well under a thousand cycles
    initial begin
        #100000;
        err_count++;
        give_verdict();
    end

    initial begin
        seed = 17688;
        err_count = 0;
        n_tests = 0;
        srst = 1'b1;
        regWr = 1'b0;
        regRd = 1'b0;
        regAddr = 4'h0;
        regWrData = 8'h00;
        rdLate = 1'b0;
        rnd = $random(seed);
        rndB = rnd[7:0];
        rndK = rnd[10:8];
        rndL = rnd[14:12];
        expW = rndB[0] ? {rndB[6:0], 1'b0} : 8'h00;
        for (i = 0; i < 4096; i++) begin
            pm.mem[i] = 12'h000;
        end
        pm.mem[12'hFFF] = 12'hA00;         // jump 000
        pm.mem[12'h000] = 12'hC05;         // W = 5
        pm.mem[12'h001] = 12'h041;         // program word read
        pm.mem[12'h002] = {9'h003, rndK};  // bank select
        pm.mem[12'h003] = 12'h030;         // W to file 10, semidirect
        pm.mem[12'h004] = 12'h910;         // call 010
        pm.mem[12'h005] = 12'h003;         // sleep
        pm.mem[12'h010] = 12'h1C0;         // W = W + alias, indirect
        pm.mem[12'h011] = 12'h700;         // skip if alias bit 0 set
        pm.mem[12'h012] = 12'h040;         // clear W
        pm.mem[12'h013] = 12'h00C;         // return
        pm.mem[12'hF05] = {4'h3, rndB};    // word at {mode, W}
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        rd(`RCP_R_WREG, 8'hFF, 8'h00);
        rd(`RCP_R_STAT, 8'hFF, `RCP_STATUS_POR);
        rd(`RCP_R_PTR, 8'hFF, `RCP_PTR_POR);
        rd(`RCP_R_OPT, 8'hFF, `RCP_OPT_RST);
        rd(`RCP_R_CTRL, 8'hFF, 8'h01);
        rd({1'b1, rndL}, 8'hFF, 8'h00);
        wr(`RCP_R_CFG, {5'h00, rndK});
        rd(`RCP_R_CFG, 8'hFF, {5'h00, rndK});
        wait_halt();
        rd(`RCP_R_WREG, 8'hFF, expW);
        rd(`RCP_R_PTR, 8'hFF, {1'b1, rndK, 4'h0});
        rd(`RCP_R_STAT, 8'h18, 8'h10);
        rd(`RCP_R_CTRL, 8'hFF, 8'h09);
        // edit memory mid-cycle so no fetch races the change
        rel();
        @(negedge clk);
        pm.mem[12'h005] = 12'hA05;
        @(posedge clk);
        wr(`RCP_R_CTRL, 8'h03);
        rd(`RCP_R_STAT, 8'h18, 8'h00);
        wait_pc(12'h005);
        wr(`RCP_R_CTRL, 8'h03);
        rd(`RCP_R_STAT, 8'h18, 8'h08);
        wait_pc(12'h005);
        wr(`RCP_R_CTRL, 8'h05);
        rd(`RCP_R_STAT, 8'h18, 8'h08);
        rel();
        @(negedge clk);
        pm.mem[12'h005] = 12'h003;
        @(posedge clk);
        wait_halt();
        wr(`RCP_R_CTRL, 8'h05);
        rd(`RCP_R_STAT, 8'h18, 8'h10);
        rd(`RCP_R_CTRL, 8'hFF, 8'h01);
        rel();
        repeat (3) @(posedge clk);
        give_verdict();
    end
endmodule // test_risc_core_pipeline_and_addressing
`default_nettype wire
